//--- verilog/wdt_pkg.sv
// Package: constants of the windowed watchdog timer
`default_nettype none
package wdt_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_SERVICE = 12'h000;
  localparam logic [11:0] OFF_OPTION  = 12'h004;
  localparam logic [11:0] OFF_STATUS  = 12'h008;
  localparam logic [11:0] OFF_CAUSE   = 12'h00C;
  localparam logic [11:0] OFF_BITOP   = 12'h010;

  // ---------------------------------------------------------------
  // Service register values
  // ---------------------------------------------------------------
  localparam logic [7:0] SERVICE_KEY     = 8'hAC;
  localparam logic [7:0] SERVICE_READ_EN = 8'h9A;
  localparam logic [7:0] SERVICE_READ_DS = 8'h1A;

  // ---------------------------------------------------------------
  // Option byte fields and reset cause layout
  // ---------------------------------------------------------------
  localparam int unsigned OPT_IRQ_BIT    = 7;
  localparam int unsigned OPT_WIN_LSB    = 5;
  localparam int unsigned OPT_ENABLE_BIT = 4;
  localparam int unsigned OPT_OVF_LSB    = 1;
  localparam int unsigned OPT_STBY_BIT   = 0;
  localparam int unsigned CAUSE_WDT_BIT  = 4;
  localparam logic [7:0]  OPTION_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // Counter geometry and timing
  // ---------------------------------------------------------------
  localparam int unsigned PRESCALE_BITS = 4;
  localparam int unsigned COUNT_BITS    = 16;
  localparam logic [1:0]  INIT_CYCLES   = 2'h2;
  localparam logic [COUNT_BITS-1:0] COUNT_RESET = 16'h0000;
  localparam logic [PRESCALE_BITS-1:0] PRESCALE_LAST = 4'hF;

  // Open fraction codes
  localparam logic [1:0] WIN_25  = 2'h0;
  localparam logic [1:0] WIN_50  = 2'h1;
  localparam logic [1:0] WIN_75  = 2'h2;
  localparam logic [1:0] WIN_100 = 2'h3;

  // Block state
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_LIVE = 2'b10
  } wdt_state_t;

  // Overflow exponent of the low-speed clock for each select code
  function automatic logic [4:0] ovf_exponent(input logic [2:0] sel);
    case (sel)
      3'h0:    ovf_exponent = 5'd10;
      3'h1:    ovf_exponent = 5'd11;
      3'h2:    ovf_exponent = 5'd12;
      3'h3:    ovf_exponent = 5'd13;
      3'h4:    ovf_exponent = 5'd15;
      3'h5:    ovf_exponent = 5'd17;
      3'h6:    ovf_exponent = 5'd18;
      default: ovf_exponent = 5'd20;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- verilog/count_if.sv
// Interface between the control logic and the watchdog counter
`default_nettype none
interface count_if;
  logic        tick;
  logic        run;
  logic        clear;
  logic [2:0]  ovf_sel;
  logic [1:0]  win_sel;
  logic        win_force;
  logic [15:0] count;
  logic        overflow;
  logic        q3_hit;
  logic        window_open;

  modport ctrl (output tick, run, clear, ovf_sel, win_sel, win_force,
                input  count, overflow, q3_hit, window_open);
  modport cnt  (input  tick, run, clear, ovf_sel, win_sel, win_force,
                output count, overflow, q3_hit, window_open);
endinterface
`default_nettype wire

//--- verilog/window_counter.sv
// Prescaled watchdog counter with overflow, 75% mark and window decode
`default_nettype none
module window_counter
  import wdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  count_if.cnt     cb
);

  logic [PRESCALE_BITS-1:0] pre_reg;
  logic [PRESCALE_BITS-1:0] pre_next;
  logic [COUNT_BITS-1:0]    count_reg;
  logic [COUNT_BITS-1:0]    count_next;
  logic [4:0]               shift;
  logic [COUNT_BITS:0]      last_val;
  logic [COUNT_BITS:0]      q3_val;
  logic [COUNT_BITS:0]      close_lim;
  logic                     step;

  // ---------------------------------------------------------------
  // Thresholds in prescaled units
  // ---------------------------------------------------------------
  always_comb begin
    shift    = ovf_exponent(cb.ovf_sel) - 5'(PRESCALE_BITS);
    last_val = (17'h0_0001 << shift) - 17'h0_0001;
    q3_val   = 17'h0_0003 << (shift - 5'd2);
    case (cb.win_force ? WIN_100 : cb.win_sel)
      WIN_25:  close_lim = 17'h0_0003 << (shift - 5'd2);
      WIN_50:  close_lim = 17'h0_0001 << (shift - 5'd1);
      WIN_75:  close_lim = 17'h0_0001 << (shift - 5'd2);
      default: close_lim = 17'h0_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Next count; prescaler is not cleared by service, giving phase slip
  // ---------------------------------------------------------------
  always_comb begin
    step       = cb.tick & cb.run & (pre_reg == PRESCALE_LAST);
    pre_next   = (cb.tick & cb.run) ? pre_reg + 4'h1 : pre_reg;
    count_next = count_reg;
    if (cb.clear) begin
      count_next = COUNT_RESET;
    end else if (step) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg   <= '0;
      count_reg <= COUNT_RESET;
    end else begin
      pre_reg   <= pre_next;
      count_reg <= count_next;
    end
  end

  // Events and window state; clear priority is applied by the control side
  assign cb.count       = count_reg;
  assign cb.overflow    = step & ({1'b0, count_reg} == last_val);
  assign cb.q3_hit      = step & ({1'b0, count_reg} + 17'h0_0001 == q3_val);
  assign cb.window_open = ({1'b0, count_reg} >= close_lim);

endmodule
`default_nettype wire

//--- verilog/windowed_watchdog_timer.sv
// Windowed watchdog timer top: APB slave, option capture, service checks
//
// Overview of operation
// - Counter runs after reset release only if the enable option bit is set.
// - Three-bit overflow select picks 2^10 to 2^20 low-speed periods.
// - Software writes ACh before overflow; each valid write clears and restarts count.
// - Overflow without valid service raises an internal reset.
// - Service write with data other than ACh raises an internal reset.
// - A bit-manipulation write to the service register raises an internal reset; a read does not.
// - From the second service write, a write in the closed window resets.
// - First service write after reset clears counter regardless of window.
// - Window select opens last 25, 50, 75 or 100 percent of the period.
// - Standby run option at zero forces a fully open window.
// - In standby the counter stops unless the standby run option is set.
// - With standby run at zero, leaving standby clears the counter and resumes.
// - With the irq option set, interval irq fires at 75 percent of period.
// - Counting continues after the interval irq until service or overflow reset.
// - Valid service is accepted up to the last count before overflow.
// - Service clearing may shorten the effective period by up to 15 low-speed clock periods.
// - Counting continues during flash programming; there is no pause input.
// - Counter is clocked by pclk and advances on low-speed clock edges sampled in that domain.
// - A watchdog reset sets the flag at bit 4 of the reset cause register.
// - Service register reads 9Ah when enabled, 1Ah when disabled.
`default_nettype none
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lsclk,
  input  wire logic        standby_mode,
  input  wire logic [7:0]  option_pins,
  output logic             internal_reset_req,
  output logic             watchdog_reset_flag,
  output logic             interval_irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  count_if cb ();

  logic [2:0]  ls_sync_reg;
  logic [2:0]  ls_sync_next;
  logic [1:0]  sb_sync_reg;
  logic [1:0]  sb_sync_next;
  logic [7:0]  opt_s1_reg;
  logic [7:0]  opt_s1_next;
  logic [7:0]  opt_s2_reg;
  logic [7:0]  opt_s2_next;
  logic        sb_prev_reg;
  logic        sb_prev_next;

  wdt_state_t  state_reg;
  wdt_state_t  state_next;
  logic [1:0]  init_cnt_reg;
  logic [1:0]  init_cnt_next;
  logic [7:0]  opt_reg;
  logic [7:0]  opt_next;

  logic        first_done_reg;
  logic        first_done_next;
  logic        rst_req_reg;
  logic        rst_req_next;
  logic        flag_reg;
  logic        flag_next;
  logic        irq_reg;
  logic        irq_next;

  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  logic        access;
  logic        wr_service;
  logic        wr_bitop;
  logic        wr_cause;
  logic        standby_s;
  logic        enable_opt;
  logic        stby_run_opt;
  logic        svc_fault;
  logic        svc_valid;
  logic        fault;
  logic        standby_exit;

  // Address decode used by the error path only
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == OFF_SERVICE) || (a == OFF_OPTION) || (a == OFF_STATUS) ||
                  (a == OFF_CAUSE) || (a == OFF_BITOP);
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Low-speed clock sampled as a level, third stage only for edge find
  always_comb begin
    ls_sync_next = {ls_sync_reg[1:0], lsclk};
    sb_sync_next = {sb_sync_reg[0], standby_mode};
    opt_s1_next  = option_pins;
    opt_s2_next  = opt_s1_reg;
    sb_prev_next = standby_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_sync_reg <= '0;
      sb_sync_reg <= '0;
      opt_s1_reg  <= OPTION_RESET;
      opt_s2_reg  <= OPTION_RESET;
      sb_prev_reg <= 1'b0;
    end else begin
      ls_sync_reg <= ls_sync_next;
      sb_sync_reg <= sb_sync_next;
      opt_s1_reg  <= opt_s1_next;
      opt_s2_reg  <= opt_s2_next;
      sb_prev_reg <= sb_prev_next;
    end
  end

  assign standby_s    = sb_sync_reg[1];
  assign enable_opt   = opt_reg[OPT_ENABLE_BIT];
  assign stby_run_opt = opt_reg[OPT_STBY_BIT];

  // ---------------------------------------------------------------
  // Option capture after reset release
  // ---------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    init_cnt_next = init_cnt_reg;
    opt_next      = opt_reg;
    case (state_reg)
      ST_INIT: begin
        if (init_cnt_reg == INIT_CYCLES) begin
          opt_next   = opt_s2_reg;
          state_next = ST_LIVE;
        end else begin
          init_cnt_next = init_cnt_reg + 2'h1;
        end
      end
      ST_LIVE: begin
        opt_next = opt_reg;
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_INIT;
      init_cnt_reg <= 2'h0;
      opt_reg      <= OPTION_RESET;
    end else begin
      state_reg    <= state_next;
      init_cnt_reg <= init_cnt_next;
      opt_reg      <= opt_next;
    end
  end

  // ---------------------------------------------------------------
  // Counter control
  // ---------------------------------------------------------------
  assign standby_exit = sb_prev_reg & ~standby_s & ~stby_run_opt;

  // No flash-programming pause exists: only standby (standby run at zero), init or a clear enable bit hold the count
  assign cb.tick      = ls_sync_reg[1] & ~ls_sync_reg[2];
  assign cb.run       = (state_reg == ST_LIVE) & enable_opt
                        & (~standby_s | stby_run_opt);
  assign cb.clear     = svc_valid | fault | standby_exit;
  assign cb.ovf_sel   = opt_reg[OPT_OVF_LSB +: 3];
  assign cb.win_sel   = opt_reg[OPT_WIN_LSB +: 2];
  assign cb.win_force = ~stby_run_opt;

  window_counter u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .cb      (cb.cnt)
  );

  // ---------------------------------------------------------------
  // Service access checks
  // ---------------------------------------------------------------
  assign access     = psel & penable & pready_reg;
  assign wr_service = access & pwrite & (paddr == OFF_SERVICE);
  assign wr_bitop   = access & pwrite & (paddr == OFF_BITOP);
  assign wr_cause   = access & pwrite & (paddr == OFF_CAUSE);

  // Any bad data, bit write, or late closed-window write is a fault
  always_comb begin
    svc_fault = wr_bitop;
    svc_valid = 1'b0;
    if (wr_service) begin
      if (pwdata[7:0] != SERVICE_KEY) begin
        svc_fault = 1'b1;
      end else if (first_done_reg & ~cb.window_open) begin
        svc_fault = 1'b1;
      end else begin
        svc_valid = 1'b1;
      end
    end
  end

  // A service or standby clear in the overflow cycle wins over the overflow
  assign fault = svc_fault | (cb.overflow & ~svc_valid & ~standby_exit);

  // ---------------------------------------------------------------
  // Fault outputs, reset cause and interval interrupt
  // ---------------------------------------------------------------
  always_comb begin
    rst_req_next    = fault;
    irq_next        = cb.q3_hit & ~cb.clear & opt_reg[OPT_IRQ_BIT];
    first_done_next = first_done_reg;
    if (fault) begin
      first_done_next = 1'b0;
    end else if (svc_valid) begin
      first_done_next = 1'b1;
    end
    flag_next = flag_reg;
    if (wr_cause & pwdata[CAUSE_WDT_BIT]) begin
      flag_next = 1'b0;
    end
    if (fault) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_req_reg    <= 1'b0;
      irq_reg        <= 1'b0;
      first_done_reg <= 1'b0;
      flag_reg       <= 1'b0;
    end else begin
      rst_req_reg    <= rst_req_next;
      irq_reg        <= irq_next;
      first_done_reg <= first_done_next;
      flag_reg       <= flag_next;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, read data and error registered
  // ---------------------------------------------------------------
  always_comb begin
    pready_next  = psel & penable & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next  = 32'h0000_0000;
    if (pready_next) begin
      pslverr_next = ~addr_mapped(paddr);
      if (!pwrite) begin
        case (paddr)
          OFF_SERVICE,
          OFF_BITOP: begin
            prdata_next[7:0] = enable_opt ? SERVICE_READ_EN : SERVICE_READ_DS;
          end
          OFF_OPTION: begin
            prdata_next[7:0] = opt_reg;
          end
          OFF_STATUS: begin
            prdata_next = {13'h0000, cb.window_open, first_done_reg, cb.run, cb.count};
          end
          OFF_CAUSE: begin
            prdata_next[CAUSE_WDT_BIT] = flag_reg;
          end
          default: begin
            prdata_next = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign internal_reset_req  = rst_req_reg;
  assign watchdog_reset_flag = flag_reg;
  assign interval_irq        = irq_reg;

endmodule
`default_nettype wire

//--- dv/wdt_asserts.sv
// Port-level checker of the windowed watchdog timer
`default_nettype none
module wdt_asserts
  import wdt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lsclk,
  input wire logic        standby_mode,
  input wire logic [7:0]  option_pins,
  input wire logic        internal_reset_req,
  input wire logic        watchdog_reset_flag,
  input wire logic        interval_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Access edge decode
  // ---------------------------------------------------------------
  logic take;
  assign take = psel && penable && pready;

  default clocking main_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing one cycle after access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (pready && paddr > OFF_BITOP |-> pslverr && prdata == 32'h0)
    else $error("unmapped access without error response");
  bad_data_a: assert property (
    take && pwrite && paddr == OFF_SERVICE && pwdata[7:0] != SERVICE_KEY
    |-> ##[1:2] internal_reset_req) else $error("bad service data without reset");
  bit_access_a: assert property (
    take && pwrite && paddr == OFF_BITOP |-> ##[1:2] internal_reset_req)
    else $error("bit access without reset");
  service_read_a: assert property (
    take && !pwrite && paddr == OFF_SERVICE |-> prdata == {24'h00_0000,
      (option_pins[OPT_ENABLE_BIT] ? SERVICE_READ_EN : SERVICE_READ_DS)})
    else $error("service read value wrong");
  req_pulse_a: assert property ($rose(internal_reset_req) |=> !internal_reset_req)
    else $error("reset request longer than one cycle");
  flag_set_a: assert property (internal_reset_req |-> ##[0:1] watchdog_reset_flag)
    else $error("reset flag not set after reset request");
  flag_hold_a: assert property (
    watchdog_reset_flag && !(take && pwrite && paddr == OFF_CAUSE) |=> watchdog_reset_flag)
    else $error("reset flag dropped without clear");
  irq_pulse_a: assert property (interval_irq |=> !interval_irq)
    else $error("interval irq longer than one cycle");
  irq_off_a: assert property (!option_pins[OPT_IRQ_BIT] |-> !interval_irq)
    else $error("interval irq while option off");
  stopped_a: assert property (!option_pins[OPT_ENABLE_BIT] |-> !interval_irq)
    else $error("interval irq while counter disabled");
endmodule

bind windowed_watchdog_timer wdt_asserts u_wdt_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lsclk(lsclk), .standby_mode(standby_mode), .option_pins(option_pins),
  .internal_reset_req(internal_reset_req), .watchdog_reset_flag(watchdog_reset_flag),
  .interval_irq(interval_irq)
);
`default_nettype wire

//--- dv/windowed_watchdog_timer_test.sv
// Self-checking testbench of the windowed watchdog timer
`default_nettype none
module windowed_watchdog_timer_test
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, lsclk, standby_mode;
  logic        pready, pslverr, internal_reset_req, watchdog_reset_flag, interval_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c1, lfsr_state;
  logic [7:0]  option_pins;
  logic [1:0]  ls_div;
  logic        last_err;
  int          miscompares, n_tests, n, k;
  localparam int ovf_exp [8] = '{10, 11, 12, 13, 15, 17, 18, 20};

  windowed_watchdog_timer u_windowed_watchdog_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lsclk(lsclk), .standby_mode(standby_mode), .option_pins(option_pins),
    .internal_reset_req(internal_reset_req), .watchdog_reset_flag(watchdog_reset_flag),
    .interval_irq(interval_irq)
  );

  // System clock, and a low-speed clock of eight system periods
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    ls_div <= ls_div + 2'h1;
    if (ls_div == 2'h3) lsclk <= ~lsclk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Overflow period in system cycles for a select code
  function automatic int ovf_cycles(input logic [2:0] code);
    return (1 << ovf_exp[code]) * 8;
  endfunction

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Count within a tolerance; an unknown value fails
  task automatic near(input integer got, input int exp, input int tol);
    n_tests++;
    if ($isunknown(got) || got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read the count until it shows the given value
  task automatic poll_count(input logic [15:0] v);
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      if (rd[15:0] == v) break;
    end
    chk({16'h0000, rd[15:0]}, {16'h0000, v});
  endtask

  // Cycles until reset request (irq when sel is 1), max if none
  task automatic wait_evt(input logic sel, input int max);
    for (n = 0; n < max; n++) begin
      @(negedge pclk);
      if ((sel ? interval_irq : internal_reset_req) === 1'b1) break;
    end
  endtask

  task automatic do_reset(input logic [7:0] opt);
    @(posedge pclk);
    presetn <= 1'b0;
    option_pins <= opt;
    standby_mode <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, OFF_OPTION, 32'h0000_0000);
    chk(rd, {24'h00_0000, opt});
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    lsclk = 1'b0;
    ls_div = 2'h0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    standby_mode = 1'b0;
    option_pins = 8'h00;
    lfsr_state = 32'hea50_de00;
    // Quarter window: first service free, second one early faults
    do_reset(8'h91);
    apb(1'b0, OFF_SERVICE, 32'h0000_0000);
    chk(rd, 32'h0000_009a);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0001);
    apb(1'b1, OFF_SERVICE, 32'h0000_00ac);
    wait_evt(1'b0, 40);
    near(n, 40, 0);
    apb(1'b1, OFF_SERVICE, 32'h0000_00ac);
    wait_evt(1'b0, 4);
    near(n, 1, 1);
    apb(1'b0, OFF_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    apb(1'b1, OFF_CAUSE, 32'h0000_0010);
    apb(1'b0, OFF_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Standby run off opens the window: random upper bits, faults on bad data
    do_reset(8'hb0);
    for (k = 0; k < 8; k++) begin
      lfsr_state = lfsr_next(lfsr_state);
      if (k < 4) begin
        apb(1'b1, OFF_SERVICE, {lfsr_state[31:8], 8'hac});
        wait_evt(1'b0, 40);
        near(n, 40, 0);
      end else begin
        apb(1'b1, OFF_SERVICE, lfsr_state ^ ((lfsr_state[7:0] == 8'hac) ? 32'h1 : 32'h0));
        wait_evt(1'b0, 4);
        near(n, 1, 1);
      end
    end
    apb(1'b1, OFF_BITOP, 32'h0000_00ac);
    wait_evt(1'b0, 4);
    near(n, 1, 1);
    repeat (1000) @(posedge pclk);
    standby_mode <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    c1 = rd;
    near({16'h0000, c1[15:0]}, 7, 3);
    repeat (600) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(32'(rd[15:0]), 32'(c1[15:0]));
    standby_mode <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    near({16'h0000, rd[15:0]}, 0, 1);
    // Interval irq at three quarters, then overflow, select code 1
    do_reset(8'h93);
    wait_evt(1'b1, 20000);
    near(n, ovf_cycles(3'h1) * 3 / 4 - 20, 40);
    wait_evt(1'b0, 6000);
    near(n, ovf_cycles(3'h1) / 4, 4);
    // Half window open from count 20h, service at 28h, then on the last count, code 0
    do_reset(8'h31);
    apb(1'b1, OFF_SERVICE, 32'h0000_00ac);
    poll_count(16'h0028);
    apb(1'b1, OFF_SERVICE, 32'h0000_00ac);
    wait_evt(1'b0, 40);
    near(n, 40, 0);
    poll_count(16'h003f);
    apb(1'b1, OFF_SERVICE, 32'h0000_00ac);
    wait_evt(1'b0, 10000);
    near(n, ovf_cycles(3'h0), 150);
    // Disabled counter never overflows
    do_reset(8'h0e);
    apb(1'b0, OFF_SERVICE, 32'h0000_0000);
    chk(rd, 32'h0000_001a);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(32'(rd[16]), 32'h0000_0000);
    wait_evt(1'b0, 9000);
    near(n, 9000, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
